// [include/mie_pkg.sv]
// Opcodes, addresses and types shared by the instruction execute unit
package mie_pkg;
	localparam int PC_W = 10;
	localparam int DA_W = 7;
	localparam int OP_HI = 15, OP_LO = 10, BIT_HI = 9, BIT_LO = 7;
	localparam logic [5:0] OP_NOP = 6'h00, OP_MOV_A_M = 6'h01, OP_MOV_M_A = 6'h02;
	localparam logic [5:0] OP_MOV_A_X = 6'h03, OP_CLR_BIT = 6'h04, OP_SET_BIT = 6'h05;
	localparam logic [5:0] OP_JMP = 6'h06, OP_CALL = 6'h07, OP_SZ = 6'h08, OP_SZA = 6'h09;
	localparam logic [5:0] OP_SZ_BIT = 6'h0A, OP_SNZ_BIT = 6'h0B, OP_SIZ = 6'h0C;
	localparam logic [5:0] OP_SDZ = 6'h0D, OP_SIZA = 6'h0E, OP_SDZA = 6'h0F;
	localparam logic [5:0] OP_RET = 6'h10, OP_RET_A_X = 6'h11, OP_IRQ_EXIT = 6'h12;
	localparam logic [5:0] OP_TAB = 6'h13, OP_TAB_LAST = 6'h14, OP_CLR_M = 6'h15;
	localparam logic [5:0] OP_SET_M = 6'h16, OP_CLR_WDT = 6'h17, OP_SWAP = 6'h18;
	localparam logic [5:0] OP_SWAPA = 6'h19, OP_HALT = 6'h1A, OP_ADC = 6'h1B;
	localparam logic [5:0] OP_ADCM = 6'h1C, OP_ADD = 6'h1D, OP_ADD_TO_MEMORY = 6'h1E;
	localparam logic [5:0] OP_ADD_X = 6'h1F, OP_AND = 6'h20, OP_AND_TO_MEMORY = 6'h21;
	localparam logic [5:0] OP_AND_X = 6'h22, OP_CPL = 6'h23, OP_INVERT_TO_WORK = 6'h24, OP_DAA = 6'h25;
	localparam logic [DA_W-1:0] PCL_ADDR = 7'h06, TBLP_ADDR = 7'h07;
	localparam logic [DA_W-1:0] TBHP_ADDR = 7'h08, LOOKUP_HIGH_BYTE_ADDR = 7'h09;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h004;
	localparam logic [PC_W-9:0] LAST_PAGE = 2'h3;
	localparam logic [7:0] BYTE_ZERO = 8'h00, BYTE_ONES = 8'hFF, BYTE_ONE = 8'h01;
	localparam logic [7:0] DAA_LO_ADJ = 8'h06, DAA_HI_ADJ = 8'h60;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [11:0] ADDR_CTRL = 12'h000, ADDR_STATUS = 12'h004, ADDR_CORE = 12'h008;
	localparam int CTRL_RUN = 0, CTRL_WAKE = 1, CORE_PC_LO = 16;
	localparam logic CTRL_RUN_RESET = 1'b0;
	typedef enum logic [1:0] {MIE_RUN, MIE_DUMMY, MIE_TABLE, MIE_HALT} mie_state_t;
endpackage : mie_pkg

// [rtl/mie_execute.sv]
// Instruction execute unit with data memory, stack, flags and APB control
`timescale 1ns/10ps
`default_nettype none
module mie_execute import mie_pkg::*; #(
	parameter int STACK_DEPTH = 8,
	parameter int DMEM_WORDS = 128
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Program memory
	output logic [PC_W-1:0] o_pm_addr,
	input wire logic [15:0] i_pm_data,
	// System events
	input wire logic i_irq_pending,
	input wire logic i_watchdog_timeout,
	input wire logic i_wake,
	output logic o_irq_ack,
	output logic o_watchdog_clear,
	output logic o_sleep
);
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam int MI_W = $clog2(DMEM_WORDS);

	if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
		$error("STACK_DEPTH must be a power of two of at least 2");
	end
	if (DMEM_WORDS <= int'(LOOKUP_HIGH_BYTE_ADDR) || DMEM_WORDS > (1 << DA_W)
		|| (DMEM_WORDS & (DMEM_WORDS - 1)) != 0) begin : g_bad_dmem
		$error("DMEM_WORDS must be a power of two covering the special bytes");
	end

	typedef struct packed {
		mie_state_t state;
		logic run;
		logic advance;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] tab_addr;
		logic [MI_W-1:0] tab_dest;
		logic [7:0] work_register;
		logic carry;
		logic nibble_overflow;
		logic zero;
		logic signed_wrap_bit;
		logic watchdog_expired_bit;
		logic sleep_entered_bit;
		logic global_irq_enable;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [DMEM_WORDS-1:0][7:0] dmem;
		logic [31:0] prdata;
		logic wdt_clr;
		logic irq_ack;
	} mie_core_t;

	mie_core_t s;
	mie_core_t next_s;

	// Sum with flags packed as {signed wrap, nibble overflow, carry, result}
	function automatic logic [10:0] mie_add(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] full;
		logic [4:0] half;
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		return {(a[7] == b[7]) && (full[7] != a[7]), half[4], full[8], full[7:0]};
	endfunction : mie_add

	function automatic logic mie_mapped(input logic [11:0] addr);
		return addr == ADDR_CTRL || addr == ADDR_STATUS || addr == ADDR_CORE;
	endfunction : mie_mapped

	logic [15:0] instr;
	logic [5:0] op;
	logic [2:0] bit_sel;
	logic [7:0] imm;
	logic [DA_W-1:0] m_addr;
	logic [MI_W-1:0] m_idx;
	logic [7:0] mval;
	logic [7:0] bit_mask;
	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] target;
	logic [SP_W-1:0] sp_dec;
	logic irq_take;
	logic exec;
	logic apb_wr;
	logic wake_wr;

	assign instr = i_pm_data;
	assign op = instr[OP_HI:OP_LO];
	assign bit_sel = instr[BIT_HI:BIT_LO];
	assign imm = instr[7:0];
	assign m_addr = instr[DA_W-1:0];
	assign m_idx = m_addr[MI_W-1:0];
	assign mval = (m_addr == PCL_ADDR) ? s.pc[7:0] : s.dmem[m_idx];
	assign bit_mask = BYTE_ONE << bit_sel;
	assign pc_inc = s.pc + 1'b1;
	assign target = instr[PC_W-1:0];
	assign sp_dec = s.sp - 1'b1;
	assign irq_take = s.state == MIE_RUN && s.run && s.global_irq_enable && i_irq_pending;
	assign exec = s.state == MIE_RUN && s.run && !irq_take;
	assign apb_wr = i_psel && i_penable && i_pwrite && i_paddr == ADDR_CTRL;
	assign wake_wr = apb_wr && i_pwdata[CTRL_WAKE];

	assign o_pm_addr = (s.state == MIE_TABLE) ? s.tab_addr : s.pc;
	assign o_prdata = s.prdata;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mie_mapped(i_paddr);
	assign o_irq_ack = s.irq_ack;
	assign o_watchdog_clear = s.wdt_clr;
	assign o_sleep = s.state == MIE_HALT;

	always_comb begin
		logic wr_en;
		logic [7:0] wr_data;
		logic skip;
		logic [10:0] sum;
		logic [7:0] res;
		logic [7:0] adj;
		wr_en = 1'b0;
		wr_data = BYTE_ZERO;
		skip = 1'b0;
		sum = '0;
		res = BYTE_ZERO;
		adj = BYTE_ZERO;
		next_s = s;
		next_s.wdt_clr = 1'b0;
		next_s.irq_ack = 1'b0;
		if (i_psel && !i_penable) begin
			if (i_paddr == ADDR_CTRL) begin
				next_s.prdata = 32'(s.run);
			end else if (i_paddr == ADDR_STATUS) begin
				next_s.prdata = 32'({s.state == MIE_HALT, s.global_irq_enable,
					s.sleep_entered_bit, s.watchdog_expired_bit, s.signed_wrap_bit,
					s.zero, s.nibble_overflow, s.carry});
			end else if (i_paddr == ADDR_CORE) begin
				next_s.prdata = (32'(s.pc) << CORE_PC_LO) | 32'(s.work_register);
			end else begin
				next_s.prdata = '0;
			end
		end
		if (apb_wr) begin
			next_s.run = i_pwdata[CTRL_RUN];
		end
		case (s.state)
			MIE_RUN: begin
				if (irq_take) begin
					// Vector entry behaves like a call and costs a dummy cycle
					next_s.stack[s.sp] = s.pc;
					next_s.sp = s.sp + 1'b1;
					next_s.pc = IRQ_VECTOR;
					next_s.global_irq_enable = 1'b0;
					next_s.irq_ack = 1'b1;
					next_s.state = MIE_DUMMY;
					next_s.advance = 1'b0;
				end else if (s.run) begin
					next_s.pc = pc_inc;
					case (op)
						OP_MOV_A_M: next_s.work_register = mval;
						OP_MOV_A_X: next_s.work_register = imm;
						OP_MOV_M_A: begin
							wr_en = 1'b1;
							wr_data = s.work_register;
						end
						OP_CLR_BIT: begin
							wr_en = 1'b1;
							wr_data = mval & ~bit_mask;
						end
						OP_SET_BIT: begin
							wr_en = 1'b1;
							wr_data = mval | bit_mask;
						end
						OP_CLR_M: begin
							wr_en = 1'b1;
							wr_data = BYTE_ZERO;
						end
						OP_SET_M: begin
							wr_en = 1'b1;
							wr_data = BYTE_ONES;
						end
						OP_JMP: begin
							next_s.pc = target;
							next_s.state = MIE_DUMMY;
							next_s.advance = 1'b0;
						end
						OP_CALL: begin
							next_s.stack[s.sp] = pc_inc;
							next_s.sp = s.sp + 1'b1;
							next_s.pc = target;
							next_s.state = MIE_DUMMY;
							next_s.advance = 1'b0;
						end
						OP_RET, OP_RET_A_X, OP_IRQ_EXIT: begin
							next_s.sp = sp_dec;
							next_s.pc = s.stack[sp_dec];
							next_s.state = MIE_DUMMY;
							next_s.advance = 1'b0;
							if (op == OP_RET_A_X) begin
								next_s.work_register = imm;
							end
							if (op == OP_IRQ_EXIT) begin
								next_s.global_irq_enable = 1'b1;
							end
						end
						OP_SZ: skip = mval == BYTE_ZERO;
						OP_SZA: begin
							next_s.work_register = mval;
							skip = mval == BYTE_ZERO;
						end
						OP_SZ_BIT: skip = !mval[bit_sel];
						OP_SNZ_BIT: skip = mval[bit_sel];
						OP_SIZ, OP_SIZA, OP_SDZ, OP_SDZA: begin
							res = (op == OP_SIZ || op == OP_SIZA) ? mval + BYTE_ONE
								: mval - BYTE_ONE;
							skip = res == BYTE_ZERO;
							if (op == OP_SIZ || op == OP_SDZ) begin
								wr_en = 1'b1;
								wr_data = res;
							end else begin
								next_s.work_register = res;
							end
						end
						OP_TAB, OP_TAB_LAST: begin
							next_s.tab_addr = (op == OP_TAB_LAST)
								? {LAST_PAGE, s.dmem[TBLP_ADDR[MI_W-1:0]]}
								: {s.dmem[TBHP_ADDR[MI_W-1:0]][PC_W-9:0],
									s.dmem[TBLP_ADDR[MI_W-1:0]]};
							next_s.tab_dest = m_idx;
							next_s.state = MIE_TABLE;
						end
						OP_CLR_WDT: begin
							next_s.wdt_clr = 1'b1;
							next_s.watchdog_expired_bit = 1'b0;
							next_s.sleep_entered_bit = 1'b0;
						end
						OP_SWAP: begin
							wr_en = 1'b1;
							wr_data = {mval[3:0], mval[7:4]};
						end
						OP_SWAPA: next_s.work_register = {mval[3:0], mval[7:4]};
						OP_HALT: begin
							next_s.wdt_clr = 1'b1;
							next_s.watchdog_expired_bit = 1'b0;
							next_s.sleep_entered_bit = 1'b1;
							next_s.state = MIE_HALT;
						end
						OP_ADC, OP_ADCM, OP_ADD, OP_ADD_TO_MEMORY, OP_ADD_X: begin
							sum = mie_add(s.work_register, (op == OP_ADD_X) ? imm : mval,
								(op == OP_ADC || op == OP_ADCM) && s.carry);
							{next_s.signed_wrap_bit, next_s.nibble_overflow, next_s.carry} =
								sum[10:8];
							next_s.zero = sum[7:0] == BYTE_ZERO;
							if (op == OP_ADCM || op == OP_ADD_TO_MEMORY) begin
								wr_en = 1'b1;
								wr_data = sum[7:0];
							end else begin
								next_s.work_register = sum[7:0];
							end
						end
						OP_AND, OP_AND_TO_MEMORY, OP_AND_X: begin
							res = s.work_register & ((op == OP_AND_X) ? imm : mval);
							next_s.zero = res == BYTE_ZERO;
							if (op == OP_AND_TO_MEMORY) begin
								wr_en = 1'b1;
								wr_data = res;
							end else begin
								next_s.work_register = res;
							end
						end
						OP_CPL, OP_INVERT_TO_WORK: begin
							res = ~mval;
							next_s.zero = res == BYTE_ZERO;
							if (op == OP_CPL) begin
								wr_en = 1'b1;
								wr_data = res;
							end else begin
								next_s.work_register = res;
							end
						end
						OP_DAA: begin
							if (s.work_register[3:0] > BCD_MAX || s.nibble_overflow) begin
								adj = adj | DAA_LO_ADJ;
							end
							if (s.work_register[7:4] > BCD_MAX || s.carry) begin
								adj = adj | DAA_HI_ADJ;
							end
							sum = mie_add(s.work_register, adj, 1'b0);
							next_s.carry = s.carry || sum[8] || adj[5];
							wr_en = 1'b1;
							wr_data = sum[7:0];
						end
						default: begin
						end
					endcase
					if (skip) begin
						next_s.state = MIE_DUMMY;
						next_s.advance = 1'b1;
					end
					if (wr_en) begin
						if (m_addr == PCL_ADDR) begin
							next_s.pc = {s.pc[PC_W-1:8], wr_data};
							next_s.state = MIE_DUMMY;
							next_s.advance = 1'b0;
						end else begin
							next_s.dmem[m_idx] = wr_data;
						end
					end
				end
			end
			MIE_DUMMY: begin
				// The fetched word is discarded; a skip still steps past it
				if (s.advance) begin
					next_s.pc = pc_inc;
				end
				next_s.state = MIE_RUN;
			end
			MIE_TABLE: begin
				next_s.dmem[s.tab_dest] = i_pm_data[7:0];
				next_s.dmem[LOOKUP_HIGH_BYTE_ADDR[MI_W-1:0]] = i_pm_data[15:8];
				next_s.state = MIE_RUN;
			end
			MIE_HALT: begin
				if (i_wake || wake_wr) begin
					next_s.state = MIE_RUN;
				end
			end
			default: next_s.state = MIE_RUN;
		endcase
		// A timeout in the same cycle as a clear still sets the bit
		if (i_watchdog_timeout) begin
			next_s.watchdog_expired_bit = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
			s.run <= CTRL_RUN_RESET;
		end else begin
			s <= next_s;
		end
	end

	logic [3:0] flags;
	logic [PC_W-1:0] stack_top;
	assign flags = {s.signed_wrap_bit, s.nibble_overflow, s.zero, s.carry};
	assign stack_top = s.stack[sp_dec];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_dummy_back;
		(s.state == MIE_DUMMY) ##1 (s.state == MIE_RUN);
	endsequence
	sequence s_skip_taken;
		exec && (op == OP_SZ || op == OP_SZA) && mval == BYTE_ZERO && m_addr != PCL_ADDR;
	endsequence

	a_move_flags: assert property (exec && op == OP_MOV_A_M |=> $stable(flags)
		&& s.work_register == $past(mval)) else $error("move changed flags or missed");
	a_bit_clear: assert property (exec && op == OP_CLR_BIT && m_addr != PCL_ADDR
		|=> s.dmem[$past(m_idx)] == ($past(mval) & ~$past(bit_mask))
		&& $stable(flags)) else $error("bit clear wrong");
	a_byte_set: assert property (exec && op == OP_SET_M && m_addr != PCL_ADDR
		|=> s.dmem[$past(m_idx)] == BYTE_ONES) else $error("byte set wrong");
	a_skip_cycles: assert property (s_skip_taken |=> s_dummy_back)
		else $error("skip did not take two cycles");
	a_skip_pc: assert property (s_skip_taken |-> ##2 s.pc == $past(pc_inc, 2) + 1'b1)
		else $error("skip did not step past next word");
	a_pcl_write: assert property (exec && op == OP_MOV_M_A && m_addr == PCL_ADDR
		|=> s.pc[7:0] == $past(s.work_register) ##0 s_dummy_back)
		else $error("pcl write not two cycles");
	a_jump_load: assert property (exec && op == OP_JMP
		|=> s.pc == $past(target) ##0 s_dummy_back) else $error("jump wrong");
	a_call_push: assert property (exec && op == OP_CALL |=> stack_top == $past(pc_inc)
		&& s.pc == $past(target)) else $error("call push wrong");
	a_return_pop: assert property (exec && op == OP_RET_A_X |=> s.pc == $past(stack_top)
		&& s.work_register == $past(imm) ##0 s_dummy_back) else $error("return wrong");
	a_irq_exit: assert property (exec && op == OP_IRQ_EXIT |=> s.global_irq_enable
		&& $stable(flags)) else $error("irq exit wrong");
	a_wdt_clear: assert property (exec && op == OP_CLR_WDT && !i_watchdog_timeout
		|=> !s.watchdog_expired_bit && !s.sleep_entered_bit && o_watchdog_clear)
		else $error("watchdog clear wrong");
	a_halt_entry: assert property (exec && op == OP_HALT |=> o_sleep && s.sleep_entered_bit
		&& o_watchdog_clear) else $error("halt entry wrong");
	a_and_zero: assert property (exec && op == OP_AND_X |=> s.zero
		== ($past(s.work_register & imm) == BYTE_ZERO) && s.carry == $past(s.carry))
		else $error("and zero flag wrong");
endmodule : mie_execute
`default_nettype wire

// [verif/mcu_instruction_execute_tb.sv]
// Self-checking bench for the instruction execute unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module mcu_instruction_execute_tb import mie_pkg::*; ;
	localparam logic [15:0] HLT = {OP_HALT, 10'h000};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic irq = 1'b0;
	logic wdt_to = 1'b0;
	logic wake = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq_ack, wd_clr, sleep;
	logic [PC_W-1:0] pm_addr;
	logic [15:0] pm_data;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int acks = 0;
	int clrs = 0;
	mie_execute DUT (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
		.i_irq_pending(irq), .i_watchdog_timeout(wdt_to), .i_wake(wake), .o_irq_ack(irq_ack),
		.o_watchdog_clear(wd_clr), .o_sleep(sleep));
	mie_pmem_model PM (.i_addr(pm_addr), .o_data(pm_data));
	initial begin
		forever #50 clk = ~clk;
	end
	// Pulse counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq_ack === 1'b1) acks <= acks + 1;
		if (wd_clr === 1'b1) clrs <= clrs + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("ERROR %0t: timeout", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		// Leave one edge after any earlier transfer so no strobe is driven twice at once
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1) begin
			err_count++;
			$display("ERROR %0t: no ready on register bus", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd
	task automatic load(input logic [15:0] p[]);
		for (int i = 0; i < (1 << PC_W); i++) begin
			PM.mem[i] = (i < p.size()) ? p[i] : 16'h0000;
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		acks = 0;
		clrs = 0;
		@(posedge clk);
	endtask : load
	// Start or wake the core, count falling edges until it halts again
	task automatic go(output int k);
		logic [31:0] q;
		logic e;
		apb(1'b1, ADDR_CTRL, 32'h3, q, e);
		k = 0;
		while (sleep !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (sleep !== 1'b1 && k < 300);
		if (sleep !== 1'b1) begin
			err_count++;
			$display("ERROR %0t: core never halted", $time);
		end
		@(posedge clk);
	endtask : go
	task automatic stop_chk(input logic [7:0] a, input logic [3:0] f, output int k);
		logic [31:0] q;
		go(k);
		rd(ADDR_CORE, q);
		`CHK(q[7:0], a)
		rd(ADDR_STATUS, q);
		`CHK(q[3:0], f)
	endtask : stop_chk
	task automatic t_move();
		int k;
		load('{{OP_MOV_A_X, 10'h001}, {OP_ADD_X, 10'h0FF}, {OP_MOV_A_X, 10'h05A},
			{OP_MOV_M_A, 10'h010}, {OP_SET_M, 10'h011}, {OP_CLR_BIT, 3'h3, 7'h11},
			{OP_SET_BIT, 3'h0, 7'h10}, HLT, {OP_MOV_A_M, 10'h011}, HLT,
			{OP_MOV_A_M, 10'h010}, HLT, {OP_CLR_M, 10'h011}, {OP_MOV_A_M, 10'h011}, HLT});
		stop_chk(8'h5A, 4'h7, k);
		`CHK(k, 9)
		stop_chk(8'hF7, 4'h7, k);
		stop_chk(8'h5B, 4'h7, k);
		stop_chk(8'h00, 4'h7, k);
		$display("move test done");
	endtask : t_move
	task automatic t_skip();
		int k;
		load('{{OP_SZ, 10'h020}, {OP_MOV_A_X, 10'h011}, {OP_SZ_BIT, 3'h0, 7'h20},
			{OP_MOV_A_X, 10'h022}, {OP_SNZ_BIT, 3'h0, 7'h20}, {OP_SIZ, 10'h021},
			{OP_SDZ, 10'h021}, {OP_MOV_A_X, 10'h033}, {OP_MOV_A_X, 10'h044}, {OP_SZA, 10'h021},
			{OP_MOV_A_X, 10'h055}, HLT, {OP_SIZA, 10'h021}, HLT, {OP_SZ, 10'h021},
			{OP_MOV_A_X, 10'h066}, HLT});
		stop_chk(8'h00, 4'h0, k);
		`CHK(k, 13)
		stop_chk(8'h01, 4'h0, k);
		stop_chk(8'h01, 4'h0, k);
		$display("skip test done");
	endtask : t_skip
	task automatic t_branch();
		int k;
		load('{{OP_CALL, 10'h006}, {OP_JMP, 10'h003}, {OP_MOV_A_X, 10'h099},
			{OP_MOV_A_X, 10'h009}, {OP_MOV_M_A, 10'h006}, HLT, {OP_RET_A_X, 10'h07E},
			{OP_NOP, 10'h000}, {OP_NOP, 10'h000}, HLT, {OP_CALL, 10'h006}, HLT});
		stop_chk(8'h09, 4'h0, k);
		`CHK(k, 11)
		stop_chk(8'h7E, 4'h0, k);
		$display("branch test done");
	endtask : t_branch
	task automatic t_irq();
		int k;
		logic [31:0] q;
		load('{{OP_CALL, 10'h006}, HLT, HLT, {OP_NOP, 10'h000}, {OP_MOV_A_X, 10'h04C}, HLT,
			{OP_IRQ_EXIT, 10'h000}});
		stop_chk(8'h00, 4'h0, k);
		`CHK(k, 6)
		rd(ADDR_STATUS, q);
		`CHK(q[6], 1'b1)
		irq <= 1'b1;
		stop_chk(8'h4C, 4'h0, k);
		rd(ADDR_STATUS, q);
		`CHK({q[6], acks[3:0]}, 5'h01)
		stop_chk(8'h4C, 4'h0, k);
		rd(ADDR_STATUS, q);
		`CHK({q[6], acks[3:0]}, 5'h02)
		irq <= 1'b0;
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_table();
		int k;
		load('{{OP_MOV_A_X, 10'h020}, {OP_MOV_M_A, 10'h007}, {OP_MOV_A_X, 10'h001},
			{OP_MOV_M_A, 10'h008}, {OP_TAB, 10'h030}, {OP_MOV_A_M, 10'h009}, HLT,
			{OP_MOV_A_M, 10'h030}, HLT, {OP_TAB_LAST, 10'h031}, {OP_MOV_A_M, 10'h031}, HLT,
			{OP_MOV_A_M, 10'h009}, HLT});
		PM.mem[10'h020] = 16'h1234;
		PM.mem[10'h120] = 16'hA55A;
		PM.mem[10'h320] = 16'hC33C;
		stop_chk(8'hA5, 4'h0, k);
		`CHK(k, 9)
		stop_chk(8'h5A, 4'h0, k);
		stop_chk(8'h3C, 4'h0, k);
		stop_chk(8'hC3, 4'h0, k);
		$display("table test done");
	endtask : t_table
	task automatic t_alu();
		int k;
		load('{{OP_MOV_A_X, 10'h07F}, {OP_ADD_X, 10'h001}, HLT, {OP_MOV_M_A, 10'h040},
			{OP_ADD_TO_MEMORY, 10'h040}, HLT, {OP_ADC, 10'h040}, HLT, {OP_AND_X, 10'h00F},
			{OP_AND_TO_MEMORY, 10'h040}, {OP_INVERT_TO_WORK, 10'h040}, HLT, {OP_MOV_A_M, 10'h040}, HLT,
			{OP_MOV_A_X, 10'h03C}, {OP_MOV_M_A, 10'h041}, {OP_SWAP, 10'h041}, {OP_CPL, 10'h041},
			{OP_SWAPA, 10'h041}, HLT, {OP_MOV_A_X, 10'h0B7}, {OP_DAA, 10'h042},
			{OP_MOV_A_M, 10'h042}, HLT});
		stop_chk(8'h80, 4'hA, k);
		stop_chk(8'h80, 4'hD, k);
		stop_chk(8'h81, 4'h0, k);
		stop_chk(8'hFF, 4'h0, k);
		stop_chk(8'h00, 4'h0, k);
		stop_chk(8'hC3, 4'h0, k);
		stop_chk(8'h17, 4'h1, k);
		$display("alu test done");
	endtask : t_alu
	task automatic t_watch();
		int k;
		logic [31:0] q;
		logic e;
		load('{{OP_CLR_WDT, 10'h000}, HLT, {OP_CLR_WDT, 10'h000}, {OP_JMP, 10'h003}});
		rd(ADDR_CTRL, q);
		`CHK(q, 32'h0)
		rd(ADDR_CORE, q);
		`CHK(q, 32'h0)
		apb(1'b0, 12'hFFC, 32'h0, q, e);
		`CHK({e, q}, 33'h1_0000_0000)
		wdt_to <= 1'b1;
		@(posedge clk);
		wdt_to <= 1'b0;
		@(posedge clk);
		rd(ADDR_STATUS, q);
		`CHK(q[5:4], 2'h1)
		go(k);
		rd(ADDR_STATUS, q);
		`CHK({q[7:4], clrs[3:0]}, 8'hA2)
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (8) @(posedge clk);
		rd(ADDR_STATUS, q);
		`CHK({q[7:4], clrs[3:0]}, 8'h03)
		$display("watchdog test done");
	endtask : t_watch
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_watch();
		t_move();
		t_skip();
		t_branch();
		t_irq();
		t_table();
		t_alu();
		close_out();
	end
endmodule : mcu_instruction_execute_tb
`default_nettype wire

// [verif/mie_pmem_model.sv]
// Program memory model answering the fetch port in the same cycle
`timescale 1ns/10ps
`default_nettype none
module mie_pmem_model import mie_pkg::*; (
	// Fetch port
	input wire logic [PC_W-1:0] i_addr,
	output logic [15:0] o_data
);
	logic [15:0] mem [0:(1<<PC_W)-1];
	// Combinational word read: instruction and table fetch see it at once
	assign o_data = mem[i_addr];
endmodule : mie_pmem_model
`default_nettype wire
